// ===== verilog/ats_pkg.sv
package ats_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_DELAY   = 8'h04;
  localparam logic [7:0] ADDR_COUNT   = 8'h08;
  localparam logic [7:0] ADDR_CMD     = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_DONECNT = 8'h14;

  // ==========================================================================
  // Control fields
  // ==========================================================================
  localparam int CTRL_SRC_LSB    = 0;
  localparam int CTRL_SLOPE_BIT  = 2;
  localparam int CTRL_DLYMAN_BIT = 3;
  localparam int CTRL_POL_BIT    = 4;
  localparam int CMD_SINGLE_BIT  = 0;
  localparam int CMD_RUN_BIT     = 1;
  localparam int CMD_STOP_BIT    = 2;

  // ==========================================================================
  // Reset values and limits
  // ==========================================================================
  localparam logic [31:0] COUNT_RESET = 32'h0000_0001;
  localparam logic [31:0] COUNT_MAX   = 32'h23C3_45FF;
  localparam logic [31:0] DELAY_RESET = 32'h0000_0000;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ           = 50_000_000;
  localparam int AUTO_DELAY_US    = 1;
  localparam int AUTO_DELAY_CYC   = (CLK_HZ / 1_000_000) * AUTO_DELAY_US;
  localparam int PULSE_NS         = 1000;
  localparam int PULSE_CYC        = (PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SAMPLE_DIV_CYC   = 4;

  typedef enum logic [1:0] {
    SRC_AUTO   = 2'b00,
    SRC_SINGLE = 2'b01,
    SRC_EXT    = 2'b10
  } ats_src_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DELAY  = 2'b01,
    ST_SAMPLE = 2'b10
  } ats_state_e;

endpackage : ats_pkg

// ===== verilog/ats_divider.sv
`timescale 1ns/1ps
module ats_divider #(
  parameter int DIV = 4
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic run,
  output logic      tick
);
  initial begin
    if (DIV < 1 || DIV > 65536) $error("DIV out of range");
  end

  logic [15:0] cnt_q;
  wire         wrap = (cnt_q == 16'(DIV - 1));

  // Restarts with each run so the first sample comes a full period in
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      tick  <= wrap;
    end
  end
endmodule : ats_divider

// ===== verilog/ats_sequencer.sv
// Functional notes
// [RULE_01] Sources: auto, single, external trigger
// [RULE_02] Auto via source select or run/stop
// [RULE_03] External mode uses rear trigger input
// [RULE_04] External edge polarity selectable
// [RULE_05] Delay wait precedes sampling
// [RULE_06] Delay modes: automatic or manual value
// [RULE_07] Each trigger takes programmed sample count
// [RULE_08] Sample count limited to 1..599999999
// [RULE_09] Sample count resets to one
// [RULE_10] Completion pulse polarity selectable
// [RULE_11] External mode pulses completion output
// [RULE_12] Single mode: one sequence per request
// [RULE_13] Auto mode re-arms immediately
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ats_sequencer
  import ats_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLE_DIV_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Front controls and rear pins
  input  wire logic        run_stop_key,
  input  wire logic        single_key,
  input  wire logic        external_trigger_input,
  output logic             completion_pulse_output,
  output logic             sample_strobe,
  output logic             busy
);

  initial begin
    if (SAMPLE_DIV < 1 || SAMPLE_DIV > 65535) $error("SAMPLE_DIV out of range");
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [4:0]  ctrl_q;
  logic [31:0] delay_q;
  logic [31:0] count_q;
  logic        run_q;
  logic [31:0] done_cnt_q;
  logic        err_q;

  logic        aw_held_q, w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  ats_state_e  state_q;
  logic [31:0] tmr_q;
  logic [31:0] smp_q;
  logic        single_pend_q;
  logic        ext_prev_q;
  logic [7:0]  pulse_q;

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire [1:0]  src_sel   = ctrl_q[CTRL_SRC_LSB +: 2];
  wire        slope_neg = ctrl_q[CTRL_SLOPE_BIT];
  wire        dly_man   = ctrl_q[CTRL_DLYMAN_BIT];
  wire        pol_neg   = ctrl_q[CTRL_POL_BIT];

  wire        wr_go     = aw_held_q && w_held_q && !s_axi_bvalid;
  wire        aw_hs     = s_axi_awvalid && s_axi_awready;
  wire        w_hs      = s_axi_wvalid && s_axi_wready;
  wire        ar_hs     = s_axi_arvalid && s_axi_arready;
  wire        aw_held_d = !wr_go && (aw_held_q || aw_hs);
  wire        w_held_d  = !wr_go && (w_held_q || w_hs);
  wire        bvalid_d  = wr_go || (s_axi_bvalid && !s_axi_bready);
  wire        rvalid_d  = ar_hs || (s_axi_rvalid && !s_axi_rready);
  wire [31:0] wmask     = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire        wr_ctrl   = wr_go && (awaddr_q == ADDR_CTRL);
  wire        wr_delay  = wr_go && (awaddr_q == ADDR_DELAY);
  wire        wr_count  = wr_go && (awaddr_q == ADDR_COUNT);
  wire        wr_cmd    = wr_go && (awaddr_q == ADDR_CMD);
  wire        wr_known  = wr_ctrl || wr_delay || wr_count || wr_cmd;
  wire [31:0] count_new = (count_q & ~wmask) | (wdata_q & wmask);
  wire        count_ok  = (count_new >= 32'h0000_0001) && (count_new <= COUNT_MAX); // see [RULE_08]

  wire        cmd_single = wr_cmd && wdata_q[CMD_SINGLE_BIT];
  wire        cmd_run    = wr_cmd && wdata_q[CMD_RUN_BIT];
  wire        cmd_stop   = wr_cmd && wdata_q[CMD_STOP_BIT];

  // Auto either by selector or by the run/stop toggle
  wire        auto_on   = (src_sel == SRC_AUTO) || run_q; // see [RULE_02]
  wire        ext_mode  = (src_sel == SRC_EXT) && !run_q;
  wire        ext_rise  = external_trigger_input && !ext_prev_q;
  wire        ext_fall  = !external_trigger_input && ext_prev_q;
  wire        ext_edge  = ext_mode && (slope_neg ? ext_fall : ext_rise); // see [RULE_03] [RULE_04]
  wire        single_mode = (src_sel == SRC_SINGLE) && !run_q;
  wire        trig      = auto_on || ext_edge || (single_mode && single_pend_q); // see [RULE_01]

  wire [31:0] dly_load  = dly_man ? delay_q : 32'(AUTO_DELAY_CYC); // see [RULE_06]
  wire        tick;
  wire        smp_last  = (state_q == ST_SAMPLE) && tick && (smp_q == 32'h0000_0001);

  ats_divider #(
    .DIV (SAMPLE_DIV)
  ) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (state_q == ST_SAMPLE),
    .tick    (tick)
  );

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      // Readies are registered from next state, same timing as a decode
      s_axi_awready <= !aw_held_d && !bvalid_d;
      s_axi_wready  <= !w_held_d && !bvalid_d;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (!wr_known || (wr_count && !count_ok)) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      ADDR_CTRL:    rd_mux = {27'h0, ctrl_q};
      ADDR_DELAY:   rd_mux = delay_q;
      ADDR_COUNT:   rd_mux = count_q;
      ADDR_CMD:     rd_mux = 32'h0000_0000;
      ADDR_STATUS:  rd_mux = {27'h0, err_q, run_q, single_pend_q, state_q};
      ADDR_DONECNT: rd_mux = done_cnt_q;
      default:      rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !rvalid_d;
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Settings
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q  <= 5'h00;
      delay_q <= DELAY_RESET;
      count_q <= COUNT_RESET; // see [RULE_09]
      err_q   <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= (ctrl_q & ~wmask[4:0]) | (wdata_q[4:0] & wmask[4:0]);
      if (wr_delay) delay_q <= (delay_q & ~wmask) | (wdata_q & wmask);
      // Out-of-range counts are refused, old value kept
      if (wr_count && count_ok) count_q <= count_new; // see [RULE_08]
      if (wr_count) err_q <= !count_ok;
    end
  end

  // Run/stop: key or command toggles, explicit stop clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 1'b0;
    end else if (cmd_stop) begin
      run_q <= 1'b0;
    end else if (run_stop_key || cmd_run) begin
      run_q <= !run_q; // see [RULE_02]
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q       <= ST_IDLE;
      tmr_q         <= 32'h0000_0000;
      smp_q         <= 32'h0000_0000;
      single_pend_q <= 1'b0;
      ext_prev_q    <= 1'b0;
      done_cnt_q    <= 32'h0000_0000;
    end else begin
      ext_prev_q <= external_trigger_input;
      // New request wins over consumption in the same cycle
      if (single_key || cmd_single) begin
        single_pend_q <= 1'b1;
      end else if (state_q == ST_IDLE && single_mode) begin
        single_pend_q <= 1'b0; // see [RULE_12]
      end
      case (state_q)
        ST_IDLE: begin
          if (trig) begin
            state_q <= ST_DELAY;
            tmr_q   <= dly_load; // see [RULE_05]
            smp_q   <= count_q;
          end
        end
        ST_DELAY: begin
          if (tmr_q == 32'h0000_0000) begin
            state_q <= ST_SAMPLE;
          end else begin
            tmr_q <= tmr_q - 32'h0000_0001;
          end
        end
        ST_SAMPLE: begin
          if (tick) smp_q <= smp_q - 32'h0000_0001; // see [RULE_07]
          if (smp_last) begin
            done_cnt_q <= done_cnt_q + 32'h0000_0001;
            // Auto rearms directly, skipping idle
            if (auto_on) begin
              state_q <= ST_DELAY; // see [RULE_13]
              tmr_q   <= dly_load;
              smp_q   <= count_q;
            end else begin
              state_q <= ST_IDLE; // see [RULE_12]
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_q                 <= 8'h00;
      completion_pulse_output <= 1'b0;
      sample_strobe           <= 1'b0;
      busy                    <= 1'b0;
    end else begin
      if (smp_last && ext_mode) begin
        pulse_q <= 8'(PULSE_CYC); // see [RULE_11]
      end else if (pulse_q != 8'h00) begin
        pulse_q <= pulse_q - 8'h01;
      end
      // Idle level follows polarity, so a polarity change moves the line
      completion_pulse_output <= (pulse_q != 8'h00) ^ pol_neg; // see [RULE_10]
      sample_strobe           <= (state_q == ST_SAMPLE) && tick;
      busy                    <= (state_q != ST_IDLE);
    end
  end

endmodule : ats_sequencer

// ===== bench/ats_sequencer_asserts.sv
`timescale 1ns/1ps
module ats_sequencer_asserts (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Rear pins
  input wire logic        completion_pulse_output,
  input wire logic        sample_strobe,
  input wire logic        busy
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_bresp_time; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
  property p_rresp_time; s_rd_taken |=> s_axi_rvalid; endproperty
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  // Four-cycle divider, so a strobe never repeats sooner
  property p_strobe_gap; sample_strobe |=> !sample_strobe [*3]; endproperty
  property p_pulse_len; $changed(completion_pulse_output) |=> $stable(completion_pulse_output) [*8]; endproperty
  // Control resets to automatic source, so work starts unasked
  property p_start_auto; $rose(aresetn) |-> ##[1:4] busy; endproperty
  // Shortest delay plus divider lead keeps strobes off this long
  property p_delay_first; $rose(busy) |-> !sample_strobe [*5]; endproperty
  a_bresp_time: assert property (p_bresp_time) else $error("write response late");
  a_rresp_time: assert property (p_rresp_time) else $error("read response late");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_rhold: assert property (p_rhold) else $error("read response dropped");
  a_refuse: assert property (p_refuse) else $error("write taken while response pending");
  a_strobe_gap: assert property (p_strobe_gap) else $error("strobes too close");
  a_pulse_len: assert property (p_pulse_len) else $error("completion pulse too short");
  a_start_auto: assert property (p_start_auto) else $error("no automatic start");
  a_delay_first: assert property (p_delay_first) else $error("sample without delay");
endmodule : ats_sequencer_asserts

// ===== bench/ats_ext_partner.sv
`timescale 1ns/1ps
module ats_ext_partner (
  // Clock
  input wire logic  aclk,
  // Rear pins
  output logic      external_trigger_input,
  input  wire logic completion_pulse_output
);
  int   run_len  = 0;
  int   last_run = 0;
  int   nchg     = 0;
  logic prev     = 1'b0;
  initial external_trigger_input = 1'b0;
  // Level moves just after an edge, as a synchronous source would
  task automatic drive(input logic v);
    @(posedge aclk);
    external_trigger_input <= v;
  endtask : drive
  // Polarity-blind listener: a pulse is two changes, width is the inner run
  always @(posedge aclk) begin
    run_len <= (completion_pulse_output !== prev) ? 1 : run_len + 1;
    if (completion_pulse_output !== prev) begin
      last_run <= run_len;
      nchg     <= nchg + 1;
    end
    prev <= completion_pulse_output;
  end
endmodule : ats_ext_partner

// ===== bench/ats_sequencer_tb.sv
`timescale 1ns/1ps
module ats_sequencer_tb;
  import ats_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        run_key = 1'b0;
  logic        single_key = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid, trig, cpo, strobe, busy;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  logic [1:0]  resp;
  int          failures = 0;
  int          compares = 0;
  int          nstrb = 0;
  int          n0;

  ats_sequencer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .run_stop_key(run_key),
    .single_key(single_key), .external_trigger_input(trig), .completion_pulse_output(cpo),
    .sample_strobe(strobe), .busy(busy));
  ats_ext_partner i_part (.aclk(aclk), .external_trigger_input(trig), .completion_pulse_output(cpo));

  initial forever #10 aclk = ~aclk;
  always @(posedge aclk) if (strobe === 1'b1) nstrb++;

  // ==========================================================================
  // Bus and check tasks
  // ==========================================================================
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string n);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(n, e, rdata);
    chk(n, {30'h0, er}, {30'h0, rresp});
  endtask : rd

  task automatic wait_idle;
    int k;
    k = 0;
    repeat (4) @(posedge aclk);
    while (busy !== 1'b0 && k < 5000) begin
      @(posedge aclk);
      k++;
    end
    chk("idle", 1, busy === 1'b0);
  endtask : wait_idle

  task automatic final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_auto;
    repeat (300) @(posedge aclk);
    chk("auto busy", 1, busy === 1'b1);
    chk("auto rearm", 1, nstrb > 2);
    rd(ADDR_COUNT, 32'h1, 2'b00, "count reset");
    rd(8'h18, 32'h0, 2'b10, "unmapped");
    wr(ADDR_CTRL, 32'h1);
    wait_idle();
  endtask : t_auto

  task automatic t_count;
    wr(ADDR_COUNT, 32'h0);
    chk("zero resp", 2, resp);
    wr(ADDR_COUNT, 32'h23C3_4600);
    chk("over resp", 2, resp);
    rd(ADDR_STATUS, 32'h10, 2'b00, "count error");
    rd(ADDR_COUNT, 32'h1, 2'b00, "count kept");
    wr(ADDR_COUNT, 32'h23C3_45FF);
    chk("max resp", 0, resp);
    rd(ADDR_COUNT, 32'h23C3_45FF, 2'b00, "count max");
    wr(ADDR_COUNT, 32'h3);
  endtask : t_count

  task automatic t_single;
    wr(ADDR_DELAY, 32'h5);
    wr(ADDR_CTRL, 32'h9);
    n0 = i_part.nchg;
    nstrb = 0;
    @(posedge aclk);
    single_key <= 1'b1;
    @(posedge aclk);
    single_key <= 1'b0;
    wait_idle();
    repeat (100) @(posedge aclk);
    chk("single samples", 3, nstrb);
    wr(ADDR_CMD, 32'h1);
    wait_idle();
    chk("bus single", 6, nstrb);
    chk("no pulse", n0, i_part.nchg);
  endtask : t_single

  task automatic t_ext;
    wr(ADDR_CTRL, 32'h16);
    repeat (10) @(posedge aclk);
    chk("idle level", 1, cpo);
    n0 = i_part.nchg;
    nstrb = 0;
    i_part.drive(1'b1);
    repeat (20) @(posedge aclk);
    chk("rise ignored", 0, busy);
    i_part.drive(1'b0);
    wait_idle();
    chk("ext samples", 3, nstrb);
    repeat (80) @(posedge aclk);
    chk("pulse edges", n0 + 2, i_part.nchg);
    chk("pulse width", 50, i_part.last_run);
    // Positive slope: the rise starts work, the fall is ignored
    wr(ADDR_CTRL, 32'h12);
    n0 = i_part.nchg;
    nstrb = 0;
    i_part.drive(1'b1);
    wait_idle();
    chk("rise samples", 3, nstrb);
    i_part.drive(1'b0);
    repeat (80) @(posedge aclk);
    chk("fall ignored", 0, busy);
    chk("rise pulse edges", n0 + 2, i_part.nchg);
  endtask : t_ext

  task automatic t_run;
    wr(ADDR_CTRL, 32'h1);
    nstrb = 0;
    @(posedge aclk);
    run_key <= 1'b1;
    @(posedge aclk);
    run_key <= 1'b0;
    repeat (300) @(posedge aclk);
    chk("run busy", 1, busy === 1'b1);
    chk("run rearm", 1, nstrb > 3);
    @(posedge aclk);
    run_key <= 1'b1;
    @(posedge aclk);
    run_key <= 1'b0;
    wait_idle();
    rd(ADDR_STATUS, 32'h0, 2'b00, "run stopped");
    wr(ADDR_CMD, 32'h2);
    repeat (100) @(posedge aclk);
    chk("cmd run busy", 1, busy === 1'b1);
    wr(ADDR_CMD, 32'h4);
    wait_idle();
    rd(ADDR_STATUS, 32'h0, 2'b00, "cmd stopped");
  endtask : t_run

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_auto();
    t_count();
    t_single();
    t_ext();
    t_run();
    final_report();
  end

  // Whole run is under two thousand cycles; this is far beyond it
  initial begin
    #1_600_000;
    failures++;
    final_report();
  end
endmodule : ats_sequencer_tb

bind ats_sequencer ats_sequencer_asserts i_chk (.*);
